// >>> rtl/osma_map.svh
// constants for the or/shift/move alu slice
`ifndef OSMA_MAP_SVH
`define OSMA_MAP_SVH
`define OSMA_WIDTH 8
`define OSMA_ADDR_W 7
`define OSMA_FILE_DEPTH 128
`define OSMA_MSB 7
`define OSMA_DEST_W 1'b0
`define OSMA_DEST_F 1'b1
`define OSMA_W_RESET 8'h00
`define OSMA_FILE_RESET 8'h00
`endif

// >>> rtl/osma_pkg.sv
// types for the or/shift/move alu slice
package osma_pkg;
  // instruction codes handled by the slice
  typedef enum logic [2:0] {
    OSMA_NOP,
    OSMA_OR_WORK_WITH_FILE,
    OSMA_SHIFT_FILE_LEFT,
    OSMA_SHIFT_FILE_RIGHT,
    OSMA_MOVE_FILE
  } osma_op_t;
  // one issued instruction
  typedef struct packed {
    osma_op_t op;
    logic [6:0] addr;
    logic dest;
  } osma_instr_t;
  // unit result
  typedef struct packed {
    logic [7:0] value;
    logic zero;
    logic carry;
    logic carry_we;
  } osma_res_t;
endpackage

// >>> rtl/osma_unit.sv
// combinational operation unit of the alu slice
`timescale 1ns/100ps
`default_nettype none
`include "osma_map.svh"
module osma_unit
  import osma_pkg::*;
(
  input wire osma_op_t op,
  input wire logic [7:0] work,
  input wire logic [7:0] operand,
  output osma_res_t res
);
  // zero detect, shared by all ops
  function automatic logic osma_is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // operation select
  always_comb begin
    res = '0;
    unique case (op)
      OSMA_OR_WORK_WITH_FILE: begin
        res.value = work | operand;
        res.carry_we = 1'b0; // carry untouched
      end
      OSMA_SHIFT_FILE_LEFT: begin
        res.value = {operand[6:0], 1'b0};
        res.carry = operand[`OSMA_MSB];
        res.carry_we = 1'b1;
      end
      OSMA_SHIFT_FILE_RIGHT: begin
        res.value = {1'b0, operand[7:1]};
        res.carry = operand[0];
        res.carry_we = 1'b1;
      end
      OSMA_MOVE_FILE: begin
        res.value = operand;
      end
      default: begin
        res.value = 8'h00;
      end
    endcase
    res.zero = osma_is_zero(res.value);
  end
endmodule
`default_nettype wire

// >>> rtl/osma_slice.sv
// or/shift/move datapath slice with working and file registers
`timescale 1ns/100ps
`default_nettype none
`include "osma_map.svh"
module osma_slice
  import osma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire osma_instr_t instr,
  input wire logic carry_load,
  input wire logic carry_in,
  input wire logic file_load,
  input wire logic [7:0] load_data,
  output logic [7:0] work_reg,
  output logic zero_flag,
  output logic carry_flag,
  output logic [7:0] file_peek,
  input wire logic [6:0] peek_addr
);
  logic [7:0] file_mem [0:`OSMA_FILE_DEPTH-1]; // file registers
  logic [7:0] next_work; // working register next
  logic next_zero;
  logic next_carry;
  logic [7:0] operand; // addressed file value
  logic file_we; // write strobe, write-back or preload
  logic [7:0] file_wdata; // data written into the array
  logic [7:0] next_peek; // observation port next
  osma_res_t res; // result and flags from the unit
  osma_op_t op_eff; // op after the valid gate

  // operand read from addressed file register
  // read is combinational: a write-back at one edge is seen by the
  // instruction issued in the very next cycle, no bypass needed
  assign operand = file_mem[instr.addr];
  // idle when nothing is issued
  assign op_eff = instr_valid ? instr.op : OSMA_NOP;

  osma_unit u_unit (
    .op(op_eff),
    .work(work_reg),
    .operand(operand),
    .res(res)
  );

  // next state for working register and flags
  always_comb begin
    next_work = work_reg;
    next_zero = zero_flag;
    next_carry = carry_flag;
    file_we = 1'b0;
    file_wdata = res.value; // write-back carries the unit result
    // external carry preset, overridden by an issued shift
    if (carry_load) begin
      next_carry = carry_in;
    end
    if (op_eff != OSMA_NOP) begin
      next_zero = res.zero;
      if (res.carry_we) begin
        next_carry = res.carry;
      end
      if (instr.dest == `OSMA_DEST_W) begin
        next_work = res.value;
      end else begin
        file_we = 1'b1;
      end
    end
    // preload only in an idle cycle: the single write port must never
    // drop an issued write-back in favour of a load
    if (file_load && op_eff == OSMA_NOP) begin
      file_we = 1'b1;
      file_wdata = load_data;
    end
  end

  // working register and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      work_reg <= `OSMA_W_RESET;
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else begin
      work_reg <= next_work;
      zero_flag <= next_zero;
      carry_flag <= next_carry;
    end
  end

  // file register array; no reset so it maps to ram
  // contents stay unknown until preloaded or written back
  always_ff @(posedge clk) begin
    if (file_we) begin
      file_mem[instr.addr] <= file_wdata;
    end
  end

  // observation port next value, read from the array
  always_comb begin
    next_peek = file_mem[peek_addr];
  end

  // registered observation port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      file_peek <= `OSMA_FILE_RESET;
    end else begin
      file_peek <= next_peek;
    end
  end

  // checks, sampled on the rising edge and quiet while reset is low
  // an op counts as issued only when valid and not the idle code
  logic issued;
  assign issued = instr_valid && instr.op != OSMA_NOP;

  // or into w: both operands taken in the issuing cycle
  or_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_OR_WORK_WITH_FILE && instr.dest == `OSMA_DEST_W
    |=> work_reg == ($past(work_reg) | $past(operand)))
    else $error("or result wrong");

  // or back into the file register lands at the same address
  or_file_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_OR_WORK_WITH_FILE && instr.dest == `OSMA_DEST_F
    |=> file_mem[$past(instr.addr)] == ($past(work_reg) | $past(operand)))
    else $error("or file result wrong");

  // carry preset excluded, it may legally move the flag
  or_carry_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_OR_WORK_WITH_FILE && !carry_load
    |=> $stable(carry_flag))
    else $error("or changed carry");

  // zero follows the or result, whatever the destination
  or_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_OR_WORK_WITH_FILE
    |=> zero_flag == (($past(work_reg) | $past(operand)) == 8'h00))
    else $error("or zero wrong");

  // left shift into w: bits move up, old msb lands in carry
  left_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_SHIFT_FILE_LEFT && instr.dest == `OSMA_DEST_W
    |=> work_reg[7:1] == $past(operand[6:0]) && carry_flag == $past(operand[7]))
    else $error("left shift wrong");

  // an old carry must never leak into bit 0
  left_lsb_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_SHIFT_FILE_LEFT && instr.dest == `OSMA_DEST_W
    |=> work_reg[0] == 1'b0)
    else $error("left shift lsb not zero");

  // left shift zero flag comes from the shifted value
  left_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_SHIFT_FILE_LEFT
    |=> zero_flag == ({$past(operand[6:0]), 1'b0} == 8'h00))
    else $error("left shift zero wrong");

  // left shift back into the file register
  left_file_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_SHIFT_FILE_LEFT && instr.dest == `OSMA_DEST_F
    |=> file_mem[$past(instr.addr)] == {$past(operand[6:0]), 1'b0})
    else $error("left shift to file wrong");

  // right shift into w: zero enters the msb, old lsb lands in carry
  right_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_SHIFT_FILE_RIGHT && instr.dest == `OSMA_DEST_W
    |=> work_reg == {1'b0, $past(operand[7:1])} && carry_flag == $past(operand[0]))
    else $error("right shift wrong");

  // right shift back into the file register, shift beats a preset
  right_file_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_SHIFT_FILE_RIGHT && instr.dest == `OSMA_DEST_F
    |=> file_mem[$past(instr.addr)] == {1'b0, $past(operand[7:1])}
      && carry_flag == $past(operand[0]))
    else $error("right shift to file wrong");

  // a file destination leaves w alone
  dest_file_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.dest == `OSMA_DEST_F |=> $stable(work_reg))
    else $error("file dest touched work");

  // move into w carries the operand unchanged
  move_work_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_MOVE_FILE && instr.dest == `OSMA_DEST_W
    |=> work_reg == $past(operand))
    else $error("move value wrong");

  // zero tracks the moved value
  move_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_MOVE_FILE |=> zero_flag == ($past(operand) == 8'h00))
    else $error("move zero wrong");

  // a move onto itself as a zero test keeps the contents
  move_file_a: assert property (@(posedge clk) disable iff (!rst_n)
    issued && instr.op == OSMA_MOVE_FILE && instr.dest == `OSMA_DEST_F
    |=> file_mem[$past(instr.addr)] == $past(operand))
    else $error("self move changed file");

  // a move right after a write to its address must see the new value
  move_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    file_we ##1 (issued && instr.op == OSMA_MOVE_FILE && instr.addr == $past(instr.addr))
    |-> operand == $past(file_wdata))
    else $error("move operand address wrong");

  // main scenarios reached

  or_cov_c: cover property (@(posedge clk) issued && instr.op == OSMA_OR_WORK_WITH_FILE);
  lsl_cov_c: cover property (@(posedge clk) issued && instr.op == OSMA_SHIFT_FILE_LEFT
    && operand[7]);
  lsr_cov_c: cover property (@(posedge clk) issued && instr.op == OSMA_SHIFT_FILE_RIGHT
    && instr.dest);
  mov_cov_c: cover property (@(posedge clk) issued && instr.op == OSMA_MOVE_FILE
    && operand == 8'h00);
  self_cov_c: cover property (@(posedge clk) issued && instr.op == OSMA_MOVE_FILE
    && instr.dest == `OSMA_DEST_F);
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the or/shift/move slice
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import osma_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  osma_instr_t instr = '0;
  logic carry_load = 1'b0;
  logic carry_in = 1'b0;
  logic file_load = 1'b0;
  logic [7:0] load_data = 8'h00;
  logic [6:0] peek_addr = 7'h05;
  logic [7:0] work_reg;
  logic zero_flag;
  logic carry_flag;
  logic [7:0] file_peek;
  int bad_count = 0;
  int comparisons = 0;
  // 4 ns clock
  always #2 clk = ~clk;
  osma_slice dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .instr_valid(instr_valid),
    .instr(instr),
    .carry_load(carry_load),
    .carry_in(carry_in),
    .file_load(file_load),
    .load_data(load_data),
    .work_reg(work_reg),
    .zero_flag(zero_flag),
    .carry_flag(carry_flag),
    .file_peek(file_peek),
    .peek_addr(peek_addr)
  );
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one instruction, taken at the next rising edge; called at a falling
  // edge, valid stays high so calls run back to back, one per cycle
  task automatic issue(input osma_op_t op, input logic [6:0] a, input logic d);
    file_load = 1'b0;
    instr_valid = 1'b1;
    instr = '{op: op, addr: a, dest: d};
    @(negedge clk);
  endtask
  // preload one file register in an idle cycle; load stays high for a run
  task automatic load(input logic [6:0] a, input logic [7:0] v);
    instr_valid = 1'b0;
    instr.addr = a;
    load_data = v;
    file_load = 1'b1;
    @(negedge clk);
  endtask
  // idle, then look at one file register
  task automatic peek(input logic [6:0] a);
    instr_valid = 1'b0;
    file_load = 1'b0;
    peek_addr = a;
    repeat (2) @(negedge clk);
  endtask
  // preset carry with no instruction taken
  task automatic preset_carry();
    instr_valid = 1'b0;
    file_load = 1'b0;
    carry_load = 1'b1;
    carry_in = 1'b1;
    @(negedge clk);
    carry_load = 1'b0;
    check("carry preset", carry_flag, 8'h01);
  endtask
  // shifts back into file registers; a shift beats a carry preset
  task automatic t_shift();
    load(7'h05, 8'h96);
    load(7'h06, 8'h69);
    issue(OSMA_SHIFT_FILE_LEFT, 7'h05, 1'b1);
    check("left carry", carry_flag, 8'h01);
    check("left zero", zero_flag, 8'h00);
    issue(OSMA_SHIFT_FILE_RIGHT, 7'h06, 1'b1);
    check("right carry", carry_flag, 8'h01);
    carry_load = 1'b1;
    carry_in = 1'b1;
    issue(OSMA_SHIFT_FILE_RIGHT, 7'h06, 1'b1);
    carry_load = 1'b0;
    check("right carry over preset", carry_flag, 8'h00);
    peek(7'h05);
    check("f5 after left", file_peek, 8'h2c);
    peek(7'h06);
    check("f6 after right", file_peek, 8'h1a);
  endtask
  // left shift to w drops a preset carry; a lone msb gives zero
  task automatic t_left_carry();
    preset_carry();
    issue(OSMA_SHIFT_FILE_LEFT, 7'h06, 1'b0);
    check("left w", work_reg, 8'h34);
    check("left carry out", carry_flag, 8'h00);
    load(7'h07, 8'h80);
    issue(OSMA_SHIFT_FILE_LEFT, 7'h07, 1'b0);
    check("left w zero", work_reg, 8'h00);
    check("left zero set", zero_flag, 8'h01);
    check("left carry msb", carry_flag, 8'h01);
    peek(7'h06);
    check("f6 kept", file_peek, 8'h1a);
  endtask
  // or keeps carry, nop changes nothing, or back into a file register
  task automatic t_or_nop();
    issue(OSMA_MOVE_FILE, 7'h05, 1'b0);
    check("move to w", work_reg, 8'h2c);
    issue(OSMA_OR_WORK_WITH_FILE, 7'h06, 1'b0);
    issue(OSMA_NOP, 7'h06, 1'b1);
    check("or carry", carry_flag, 8'h01);
    check("or zero", zero_flag, 8'h00);
    check("or w", work_reg, 8'h3e);
    issue(OSMA_OR_WORK_WITH_FILE, 7'h07, 1'b1);
    peek(7'h07);
    check("or file", file_peek, 8'hbe);
    check("or file w kept", work_reg, 8'h3e);
  endtask
  // move to w, or of zeros, and a move onto itself as a zero test
  task automatic t_move();
    load(7'h09, 8'h00);
    issue(OSMA_MOVE_FILE, 7'h09, 1'b0);
    check("move w", work_reg, 8'h00);
    check("move zero", zero_flag, 8'h01);
    issue(OSMA_MOVE_FILE, 7'h05, 1'b1);
    check("self move clear", zero_flag, 8'h00);
    check("self move w kept", work_reg, 8'h00);
    issue(OSMA_OR_WORK_WITH_FILE, 7'h09, 1'b0);
    check("or zero set", zero_flag, 8'h01);
    issue(OSMA_MOVE_FILE, 7'h05, 1'b1);
    issue(OSMA_MOVE_FILE, 7'h09, 1'b1);
    check("self move zero", zero_flag, 8'h01);
    peek(7'h05);
    check("move self", file_peek, 8'h2c);
  endtask
  // verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the 31 cycles needed
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    check("w reset", work_reg, 8'h00);
    check("flags reset", {zero_flag, carry_flag}, 8'h00);
    rst_n = 1'b1;
    t_shift();
    t_left_carry();
    t_or_nop();
    t_move();
    give_verdict();
  end
endmodule
`default_nettype wire
